// ---- shared/dmc_pkg.sv ----
// Package of the two-channel transfer controller with CRC snoop.
// Assumes byte addresses on a 32-bit classic Wishbone register bus.
package dmc_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CH_SRC = 8'h00;
  localparam logic [7:0] ADR_CH_DST = 8'h04;
  localparam logic [7:0] ADR_CH_CNT = 8'h08;
  localparam logic [7:0] ADR_CH_CTL = 8'h0c;
  localparam logic [7:0] ADR_CH_STRIDE = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADR_CRC_DATA = 8'h28;
  localparam logic [7:0] ADR_CRC_SNOOP = 8'h2c;
  localparam logic [7:0] ADR_CRC_IN = 8'h30;
  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_SWREQ = 1;
  localparam int CTL_WORD = 2;
  localparam int CTL_SSTEP = 3;
  localparam int CTL_DSTEP = 4;
  localparam int CTL_SEL_LO = 5;
  localparam int CTL_PEND = 7;
  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int CNT_W = 16;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CRC_RST = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;
  // ------------------------------------------------------------
  // Request source select and engine states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DMC_SEL_SW = 2'h0,
    DMC_SEL_TMR = 2'h1,
    DMC_SEL_SER = 2'h2,
    DMC_SEL_AUD = 2'h3
  } dmc_sel_t;
  typedef enum logic [2:0] {
    DMC_IDLE = 3'b001,
    DMC_RD = 3'b010,
    DMC_WR = 3'b100
  } dmc_state_t;
endpackage

// ---- design/dmc_crc.sv ----
// CRC-CCITT accumulator, one snooped byte per clock, MSB first.
// Assumes feed pulses come from logic on the same clock.
`timescale 1ns/100ps
module dmc_crc (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic init_i, // Load seed value
  input wire logic [15:0] init_val_i, // Seed value
  input wire logic feed_i, // Accumulate one byte
  input wire logic [7:0] byte_i, // Byte to accumulate
  output logic [15:0] crc_o // Accumulated result
);
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ dmc_pkg::CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= dmc_pkg::CRC_RST;
    end else if (init_i) begin
      crc_o <= init_val_i;
    end else if (feed_i) begin
      crc_o <= crc_byte(crc_o, byte_i);
    end
  end
endmodule // dmc_crc

// ---- design/dmc_core.sv ----
// Two-channel transfer controller with CRC snoop and Wishbone slave.
// Assumes request pulses and the memory port live on clk_sys_i.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
// Function
// - Simultaneous requests: channel zero served first, channel one next.
// - One timer pulse raises requests on every enabled channel selecting it.
// - Source stepping increments source address after each unit.
// - Destination stepping increments destination address after each unit.
// - Each unit decrements counter by one, even where word units step addresses by two.
// - Counter underflow clears enable and raises channel interrupt together.
// - Units moved equal loaded count plus one.
// - Single mode moves one unit per accepted request, then waits.
// - Writing one to software request bit starts one unit, if the same write also sets the enable bit.
// - Unit is byte or word; stepping and counting per unit.
// - Configure while disabled; enable bit arms the channel.
// - A write to snoop address is copied into CRC input; a same-cycle DMA write wins over a processor one.
// - CRC unit computes CRC-CCITT; snoop register picks captured address.
// - CRC data register holds two-byte result readable afterwards.
module dmc_core (
  input wire logic clk_sys_i, // System clock, 10 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic tmr_req_i, // First interval timer underflow pulse
  input wire logic ser_req_i, // Serial port one transmit ready pulse
  input wire logic aud_req_i, // Audio port word accepted pulse
  output logic mem_cyc_o, // Memory access request
  output logic mem_we_o, // Memory write
  output logic mem_word_o, // Word access when high
  output logic [19:0] mem_adr_o, // Memory address
  output logic [15:0] mem_dat_o, // Memory write data
  input wire logic [15:0] mem_dat_i, // Memory read data
  input wire logic mem_ack_i, // Memory access done
  input wire logic cpu_wr_i, // Processor write strobe, for snoop
  input wire logic [19:0] cpu_adr_i, // Processor write address
  input wire logic [7:0] cpu_dat_i, // Processor write data, low byte
  output logic irq_o // Interrupt, level, active high
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [19:0] src [2];
  logic [19:0] dst [2];
  logic [15:0] cnt [2];
  logic [1:0] en;
  logic [1:0] word;
  logic [1:0] sstep;
  logic [1:0] dstep;
  logic [1:0] sel [2];
  logic [1:0] pend;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [19:0] snoop_adr;
  logic [7:0] crc_in;
  logic [15:0] crc_val;
  logic [15:0] buf_dat;
  logic ch;
  dmc_pkg::dmc_state_t state;

  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_a;
  logic [1:0] set_req;
  logic [1:0] grant;
  logic unit_done;
  logic next_ch;
  logic dma_snoop;
  logic cpu_snoop;
  logic crc_feed;
  logic [7:0] crc_byte_in;
  logic crc_init;
  logic [1:0] set_irq;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ch_adr(input int c, input logic [7:0] off);
    return off + ((c == 0) ? 8'h00 : dmc_pkg::ADR_CH_STRIDE);
  endfunction

  function automatic logic [19:0] unit_step(input logic is_word);
    return is_word ? dmc_pkg::STEP_WORD : dmc_pkg::STEP_BYTE;
  endfunction

  function automatic logic src_hit(input logic [1:0] s, input logic t, input logic r, input logic a);
    case (s)
      dmc_pkg::DMC_SEL_TMR: return t;
      dmc_pkg::DMC_SEL_SER: return r;
      dmc_pkg::DMC_SEL_AUD: return a;
      default: return 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Wishbone slave, one wait state, every address answered
  // ------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && (wb_sel_i != 4'h0);
  assign wb_a = {wb_adr_i[7:2], 2'b00};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= 32'h00000000;
      for (int c = 0; c < 2; c++) begin
        if (wb_a == ch_adr(c, dmc_pkg::ADR_CH_SRC)) wb_dat_o <= {12'h000, src[c]};
        if (wb_a == ch_adr(c, dmc_pkg::ADR_CH_DST)) wb_dat_o <= {12'h000, dst[c]};
        if (wb_a == ch_adr(c, dmc_pkg::ADR_CH_CNT)) wb_dat_o <= {16'h0000, cnt[c]};
        if (wb_a == ch_adr(c, dmc_pkg::ADR_CH_CTL)) begin
          wb_dat_o <= {24'h000000, pend[c], sel[c], dstep[c], sstep[c], word[c], 1'b0, en[c]};
        end
      end
      case (wb_a)
        dmc_pkg::ADR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat};
        dmc_pkg::ADR_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask};
        dmc_pkg::ADR_CRC_DATA: wb_dat_o <= {16'h0000, crc_val};
        dmc_pkg::ADR_CRC_SNOOP: wb_dat_o <= {12'h000, snoop_adr};
        dmc_pkg::ADR_CRC_IN: wb_dat_o <= {24'h000000, crc_in};
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Request capture and arbitration
  // ------------------------------------------------------------
  // A timer pulse is tested against each channel alone, so it may arm both.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      set_req[c] = en[c] && src_hit(sel[c], tmr_req_i, ser_req_i, aud_req_i);
      if (wb_wr && wb_a == ch_adr(c, dmc_pkg::ADR_CH_CTL) && wb_dat_i[dmc_pkg::CTL_SWREQ]) begin
        set_req[c] = 1'b1;
      end
    end
  end

  always_comb begin
    grant = 2'b00;
    next_ch = ch;
    if (state == dmc_pkg::DMC_IDLE) begin
      if (pend[0] && en[0]) begin
        grant = 2'b01;
        next_ch = 1'b0;
      end else if (pend[1] && en[1]) begin
        grant = 2'b10;
        next_ch = 1'b1;
      end
    end
  end

  // A request arriving as its pending flag is consumed is kept.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= 2'b00;
    end else begin
      pend <= ((pend & ~grant) | set_req) & (en | set_req);
    end
  end

  // ------------------------------------------------------------
  // Transfer engine: read the source, then write the destination
  // ------------------------------------------------------------
  assign unit_done = (state == dmc_pkg::DMC_WR) && mem_ack_i;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= dmc_pkg::DMC_IDLE;
      ch <= 1'b0;
      buf_dat <= 16'h0000;
    end else begin
      case (state)
        dmc_pkg::DMC_IDLE: begin
          if (grant != 2'b00) begin
            state <= dmc_pkg::DMC_RD;
            ch <= next_ch;
          end
        end
        dmc_pkg::DMC_RD: begin
          if (mem_ack_i) begin
            buf_dat <= word[ch] ? mem_dat_i : {8'h00, mem_dat_i[7:0]};
            state <= dmc_pkg::DMC_WR;
          end
        end
        dmc_pkg::DMC_WR: begin
          if (mem_ack_i) begin
            state <= dmc_pkg::DMC_IDLE;
          end
        end
        default: state <= dmc_pkg::DMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_cyc_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_word_o <= 1'b0;
      mem_adr_o <= dmc_pkg::ADDR_RST;
      mem_dat_o <= 16'h0000;
    end else begin
      case (state)
        dmc_pkg::DMC_IDLE: begin
          mem_cyc_o <= (grant != 2'b00);
          mem_we_o <= 1'b0;
          mem_word_o <= word[next_ch];
          mem_adr_o <= src[next_ch];
        end
        dmc_pkg::DMC_RD: begin
          if (mem_ack_i) begin
            mem_we_o <= 1'b1;
            mem_adr_o <= dst[ch];
            mem_dat_o <= word[ch] ? mem_dat_i : {8'h00, mem_dat_i[7:0]};
          end
        end
        dmc_pkg::DMC_WR: begin
          if (mem_ack_i) begin
            mem_cyc_o <= 1'b0;
            mem_we_o <= 1'b0;
          end
        end
        default: mem_cyc_o <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Channel registers: software writes, then hardware stepping
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < 2; c++) begin
        src[c] <= dmc_pkg::ADDR_RST;
        dst[c] <= dmc_pkg::ADDR_RST;
        cnt[c] <= dmc_pkg::CNT_RST;
        sel[c] <= dmc_pkg::DMC_SEL_SW;
      end
      en <= 2'b00;
      word <= 2'b00;
      sstep <= 2'b00;
      dstep <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wb_wr && wb_a == ch_adr(c, dmc_pkg::ADR_CH_SRC)) src[c] <= wb_dat_i[19:0];
        if (wb_wr && wb_a == ch_adr(c, dmc_pkg::ADR_CH_DST)) dst[c] <= wb_dat_i[19:0];
        if (wb_wr && wb_a == ch_adr(c, dmc_pkg::ADR_CH_CNT)) cnt[c] <= wb_dat_i[15:0];
        if (wb_wr && wb_a == ch_adr(c, dmc_pkg::ADR_CH_CTL)) begin
          en[c] <= wb_dat_i[dmc_pkg::CTL_EN];
          word[c] <= wb_dat_i[dmc_pkg::CTL_WORD];
          sstep[c] <= wb_dat_i[dmc_pkg::CTL_SSTEP];
          dstep[c] <= wb_dat_i[dmc_pkg::CTL_DSTEP];
          sel[c] <= wb_dat_i[dmc_pkg::CTL_SEL_LO +: 2];
        end
        // Hardware completion overrides a same-cycle register write
        if (unit_done && ch == c[0]) begin
          if (sstep[c]) src[c] <= src[c] + unit_step(word[c]);
          if (dstep[c]) dst[c] <= dst[c] + unit_step(word[c]);
          cnt[c] <= cnt[c] - 16'h0001;
          if (cnt[c] == 16'h0000) en[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      set_irq[c] = unit_done && (ch == c[0]) && (cnt[c] == 16'h0000);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      if (wb_wr && wb_a == dmc_pkg::ADR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wb_dat_i[1:0]) | set_irq;
      end else begin
        irq_stat <= irq_stat | set_irq;
      end
      if (wb_wr && wb_a == dmc_pkg::ADR_IRQ_MASK) irq_mask <= wb_dat_i[1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // CRC snoop: DMA writes take precedence over processor writes
  // ------------------------------------------------------------
  assign dma_snoop = unit_done && (mem_adr_o == snoop_adr);
  assign cpu_snoop = cpu_wr_i && (cpu_adr_i == snoop_adr);
  assign crc_feed = dma_snoop || cpu_snoop || (wb_wr && wb_a == dmc_pkg::ADR_CRC_IN);
  assign crc_byte_in = dma_snoop ? mem_dat_o[7:0] : (cpu_snoop ? cpu_dat_i : wb_dat_i[7:0]);
  assign crc_init = wb_wr && wb_a == dmc_pkg::ADR_CRC_DATA;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      snoop_adr <= dmc_pkg::ADDR_RST;
      crc_in <= 8'h00;
    end else begin
      if (wb_wr && wb_a == dmc_pkg::ADR_CRC_SNOOP) snoop_adr <= wb_dat_i[19:0];
      if (crc_feed) crc_in <= crc_byte_in;
    end
  end

  dmc_crc u_crc (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .init_val_i(wb_dat_i[15:0]),
    .feed_i(crc_feed && !crc_init),
    .byte_i(crc_byte_in),
    .crc_o(crc_val)
  );
endmodule // dmc_core

// ---- verif/dmc_core_sva.sv ----
// Port checker of the transfer controller.
// Assumes it is bound onto dmc_core and sees its ports only.
`timescale 1ns/100ps
module dmc_core_sva (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic wb_ack_o, // Bus answer
  input wire logic mem_cyc_o, // Access active
  input wire logic mem_we_o, // Write half
  input wire logic mem_word_o, // Word unit
  input wire logic [19:0] mem_adr_o, // Access address
  input wire logic [15:0] mem_dat_o, // Write data
  input wire logic [15:0] mem_dat_i, // Read data
  input wire logic mem_ack_i, // Access done
  input wire logic irq_o // Interrupt
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  AST_RD_FIRST: assert property ($rose(mem_cyc_o) |-> !mem_we_o)
    else $error("unit did not start with a read");
  AST_HOLD: assert property (mem_cyc_o && !mem_ack_i |=> mem_cyc_o && $stable(mem_adr_o)
    && $stable(mem_we_o) && $stable(mem_word_o))
    else $error("access changed before its answer");
  AST_WR_NEXT: assert property (mem_cyc_o && mem_ack_i && !mem_we_o |=> mem_cyc_o && mem_we_o)
    else $error("read not followed by write");
  AST_DAT_PASS: assert property (mem_cyc_o && mem_ack_i && !mem_we_o
    |=> mem_dat_o == ($past(mem_dat_i) & (mem_word_o ? 16'hffff : 16'h00ff)))
    else $error("write data differs from read data");
  AST_UNIT_END: assert property (mem_cyc_o && mem_ack_i && mem_we_o |=> !mem_cyc_o)
    else $error("no idle cycle after a unit");
  // A register write lands at the edge it is taken, the same edge that raises its ack
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> ($past(mem_ack_i) && $past(mem_we_o))
    || $past(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o))
    else $error("interrupt rose without a cause");
endmodule // dmc_core_sva
bind dmc_core dmc_core_sva dmc_core_sva_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
  .mem_word_o(mem_word_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i),
  .mem_ack_i(mem_ack_i), .irq_o(irq_o));

// ---- verif/dmc_mem_model.sv ----
// Memory and peripheral side model of the transfer controller.
// Assumes one access at a time; each write is logged for the bench.
`timescale 1ns/100ps
module dmc_mem_model (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic mem_cyc_i, // Access request
  input wire logic mem_we_i, // Write half
  input wire logic [19:0] mem_adr_i, // Address
  input wire logic [15:0] mem_dat_i, // Write data
  input wire logic slow_i, // Three wait cycles per access
  output logic mem_ack_o, // One-cycle answer
  output logic [15:0] mem_dat_o // Read data, valid with ack only
);
  logic [1:0] wait_cnt;
  logic [35:0] wlog [$];
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      mem_dat_o <= 16'h0000;
    end else begin
      // Junk between answers so stale data is never mistaken for valid
      mem_dat_o <= ~mem_dat_o;
      if (mem_ack_o) begin
        mem_ack_o <= 1'b0;
      end else if (mem_cyc_i && wait_cnt == (slow_i ? 2'h3 : 2'h0)) begin
        mem_ack_o <= 1'b1;
        wait_cnt <= 2'h0;
        mem_dat_o <= {~mem_adr_i[7:0], mem_adr_i[7:0] ^ mem_adr_i[15:8]};
        if (mem_we_i) begin
          wlog.push_back({mem_adr_i, mem_dat_i});
        end
      end else if (mem_cyc_i) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule // dmc_mem_model

// ---- verif/tb_two_channel_dma_with_crc_snoop.sv ----
// Self-checking bench of the transfer controller.
// Assumes dmc_core, dmc_mem_model and the bound checker are compiled.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_two_channel_dma_with_crc_snoop;
  logic clk_sys, rst, cyc, stb, we, ack, irq, slow, cpu_wr, mcyc, mwe, mword, mack;
  logic [2:0] req;
  logic [7:0] adr, cpu_dat, b;
  logic [31:0] wdat, rdat, q;
  logic [19:0] madr, cpu_adr, s, d, s2, d2, a;
  logic [15:0] mwdat, mrdat, c, e;
  logic [7:0] ra [6] = '{8'h00, 8'h0c, 8'h20, 8'h24, 8'h28, 8'h3c};
  int n_errors, n_tests, n, seed;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  dmc_core dmc_core_i (.clk_sys_i(clk_sys), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tmr_req_i(req[0]),
    .ser_req_i(req[1]), .aud_req_i(req[2]), .mem_cyc_o(mcyc), .mem_we_o(mwe), .mem_word_o(mword),
    .mem_adr_o(madr), .mem_dat_o(mwdat), .mem_dat_i(mrdat), .mem_ack_i(mack), .cpu_wr_i(cpu_wr),
    .cpu_adr_i(cpu_adr), .cpu_dat_i(cpu_dat), .irq_o(irq));
  dmc_mem_model dmc_mem_model_i (.clk_sys_i(clk_sys), .rst_i(rst), .mem_cyc_i(mcyc), .mem_we_i(mwe),
    .mem_adr_i(madr), .mem_dat_i(mwdat), .slow_i(slow), .mem_ack_o(mack), .mem_dat_o(mrdat));
  // ----------------------------------------
  // Expectations and tasks
  // ----------------------------------------
  function automatic logic [15:0] rdexp(input logic [19:0] x);
    return {~x[7:0], x[7:0] ^ x[15:8]};
  endfunction
  function automatic logic [15:0] crc8(input logic [15:0] r, input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ v[i]) ? dmc_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  task automatic stop_test;
    $display("TB: %0d compares, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    tmo(i, 20);
  endtask
  task automatic cfg(input logic [7:0] o, input logic [19:0] sa, input logic [19:0] da, input logic [15:0] cn,
    input logic [7:0] t);
    bus(1'b1, dmc_pkg::ADR_CH_SRC + o, {12'h000, sa});
    bus(1'b1, dmc_pkg::ADR_CH_DST + o, {12'h000, da});
    bus(1'b1, dmc_pkg::ADR_CH_CNT + o, {16'h0000, cn});
    bus(1'b1, dmc_pkg::ADR_CH_CTL + o, {24'h000000, t});
  endtask
  task automatic wait_log(input int k);
    int i;
    i = 0;
    while (dmc_mem_model_i.wlog.size() < k && i < 100) begin
      @(posedge clk_sys);
      i++;
    end
    tmo(i, 100);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys);
    req <= m;
    @(posedge clk_sys);
    req <= 3'h0;
  endtask
  task automatic cpu_put(input logic [19:0] x, input logic [7:0] v);
    @(posedge clk_sys);
    cpu_wr <= 1'b1;
    cpu_adr <= x;
    cpu_dat <= v;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, cyc, stb, we, slow, cpu_wr, req, adr, wdat, cpu_adr, cpu_dat} = '0;
    rst = 1'b1;
    seed = $urandom(32'h06fb);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(q, 32'h0)
    end
    $display("TB: reset values done");
    // Byte block on software requests, both addresses stepping
    n = $urandom_range(4, 1);
    s = 20'($urandom());
    d = 20'($urandom());
    bus(1'b1, dmc_pkg::ADR_IRQ_MASK, 32'h3);
    cfg(8'h00, s, d, 16'(n), 8'h18);
    for (int k = 0; k <= n; k++) begin
      bus(1'b1, dmc_pkg::ADR_CH_CTL, 32'h1b);
      wait_log(k + 1);
      `CHK(dmc_mem_model_i.wlog[k], {d + 20'(k), rdexp(s + 20'(k)) & 16'h00ff})
    end
    bus(1'b0, dmc_pkg::ADR_CH_CTL, 32'h0);
    `CHK(q[0], 1'b0)
    bus(1'b0, dmc_pkg::ADR_IRQ_STAT, 32'h0);
    `CHK(q, 32'h1)
    `CHK(irq, 1'b1)
    bus(1'b1, dmc_pkg::ADR_CH_CTL, 32'h2);
    repeat (5) @(posedge clk_sys);
    `CHK(dmc_mem_model_i.wlog.size(), n + 1)
    bus(1'b1, dmc_pkg::ADR_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    dmc_mem_model_i.wlog.delete();
    $display("TB: software block done");
    // Timer pulse shared by both channels, slow memory
    slow <= 1'b1;
    s2 = 20'($urandom()) & 20'hffffe;
    d2 = 20'($urandom()) & 20'hffffe;
    bus(1'b1, dmc_pkg::ADR_IRQ_MASK, 32'h2);
    cfg(8'h00, s, d, 16'h0001, 8'h29);
    cfg(8'h10, s2, d2, 16'h0001, 8'h35);
    for (int k = 0; k < 2; k++) begin
      pulse(3'b001);
      wait_log(2 * k + 2);
      `CHK(dmc_mem_model_i.wlog[2 * k], {d, rdexp(s + 20'(k)) & 16'h00ff})
      `CHK(dmc_mem_model_i.wlog[2 * k + 1], {d2 + 20'(2 * k), rdexp(s2)})
    end
    bus(1'b0, dmc_pkg::ADR_IRQ_STAT, 32'h0);
    `CHK(q, 32'h3)
    `CHK(irq, 1'b1)
    bus(1'b1, dmc_pkg::ADR_IRQ_STAT, 32'h2);
    `CHK(irq, 1'b0)
    bus(1'b1, dmc_pkg::ADR_IRQ_STAT, 32'h1);
    slow <= 1'b0;
    dmc_mem_model_i.wlog.delete();
    $display("TB: timer pair done");
    // Peripheral requests and snoop of unit writes
    a = 20'($urandom());
    bus(1'b1, dmc_pkg::ADR_CRC_SNOOP, {12'h000, a});
    cfg(8'h00, s, a, 16'h0000, 8'h41);
    pulse(3'b010);
    wait_log(1);
    e = rdexp(s);
    bus(1'b0, dmc_pkg::ADR_CRC_IN, 32'h0);
    `CHK(q[7:0], e[7:0])
    cfg(8'h10, s2, d2, 16'h0000, 8'h65);
    pulse(3'b100);
    wait_log(2);
    `CHK(dmc_mem_model_i.wlog[1], {d2, rdexp(s2)})
    pulse(3'b100);
    repeat (5) @(posedge clk_sys);
    `CHK(dmc_mem_model_i.wlog.size(), 2)
    bus(1'b1, dmc_pkg::ADR_IRQ_STAT, 32'h3);
    // Processor writes into the accumulator
    c = 16'($urandom());
    bus(1'b1, dmc_pkg::ADR_CRC_DATA, {16'h0000, c});
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom());
      cpu_put(a, b);
      c = crc8(c, b);
    end
    cpu_put(a ^ 20'h00001, 8'h5a);
    b = 8'($urandom());
    bus(1'b1, dmc_pkg::ADR_CRC_IN, {24'h000000, b});
    c = crc8(c, b);
    bus(1'b0, dmc_pkg::ADR_CRC_DATA, 32'h0);
    `CHK(q, {16'h0000, c})
    bus(1'b0, dmc_pkg::ADR_CRC_IN, 32'h0);
    `CHK(q[7:0], b)
    $display("TB: snoop and checksum done");
    stop_test();
  end
endmodule // tb_two_channel_dma_with_crc_snoop
